// ===== logic/ists_defs.vh
// Constants for the interrupt status tree: register offsets, bit positions, reset values.
// Assumes an 8-bit register port addressed by byte offset.
`ifndef ISTS_DEFS_VH
`define ISTS_DEFS_VH

`define ISTS_OFF_GP_PIN_STATUS 8'h41
`define ISTS_OFF_TOP_SUMMARY 8'h42
`define ISTS_OFF_GLOBAL_FUNC 8'h43
`define ISTS_OFF_INPUT_CLK 8'h44
`define ISTS_OFF_OUTPUT_CLK 8'h45
`define ISTS_OFF_ANALOG_PLL 8'h46
`define ISTS_OFF_DIGITAL_PLL 8'h47
`define ISTS_OFF_APLL_LOCK 8'h48

// Top summary fields
`define ISTS_TOP_MISC_BIT 6
`define ISTS_TOP_OUTCLK_BIT 5
`define ISTS_TOP_INCLK_BIT 4
`define ISTS_TOP_DPLL_BIT 3
`define ISTS_TOP_APLL_BIT 2
`define ISTS_TOP_GEN_BIT 1
`define ISTS_TOP_INT_BIT 0

// Global functions fields
`define ISTS_MISC_GROUP_FLAG_BOOT_BIT 7
`define ISTS_MISC_GROUP_FLAG_PA_BIT 1
`define ISTS_MISC_GROUP_FLAG_MAB_BIT 0

// Analog PLL lock status fields
`define ISTS_LK_SECOND_EN_BIT 6
`define ISTS_LK_SECOND_LAT_BIT 5
`define ISTS_LK_SECOND_BIT 4
`define ISTS_LK_BOTH_BIT 3
`define ISTS_LK_FIRST_EN_BIT 2
`define ISTS_LK_FIRST_LAT_BIT 1
`define ISTS_LK_FIRST_BIT 0

`define ISTS_REG_RESET 8'h00

`endif

// ===== logic/ists_top.v
// Interrupt status tree: group summary registers, top summary, analog PLL lock status.
// Assumes sources and enables arrive as synchronous levels from their owning blocks,
// and a simple 8-bit register port with a read strobe and a write strobe.
`timescale 1ns/10ps
`default_nettype none
`include "ists_defs.vh"

// Overview of operation
// - Status bit 0 at 0x41 shows the raw level of general-purpose pin 0.
// - Misc group flag is set while any global-functions status bit is set.
// - Output-clock group flag is set while any output-clock status bit is set.
// - Input-clock group flag is set while any input-clock status bit is set.
// - Digital PLL group flag is set while its status register is nonzero.
// - Analog PLL group flag is set while its status register is nonzero.
// - Writable global enable; when clear no source reaches the summary bit.
// - Summary bit equals global enable AND any of the five group flags.
// - A general-purpose pin can be set to follow the summary bit.
// - Boot-done flag clears on reset and sets when boot controller finishes.
// - Phase-adjust flag is set while any enabled phase-adjust latched bit is set.
// - Measurement flag is set while any enabled measurement latched bit is set.
// - Input-clock flags 1..3 follow each enabled valid-change latched bit.
// - Output-clock flags 1..3 follow any enabled latched bit of that output.
// - Analog PLL status bit 0 follows any enabled lock latched bit.
// - Digital PLL status bit 0 follows any enabled bit of its latched registers.
// - Second-lock latched bit sets on any indicator change, clears on write 1.
// - Second-lock enable bit passes or blocks its latched bit as a request.
// - Combined-lock bit is 1 only while analog and digital PLLs are locked.
// - First-lock latched bit sets on any indicator change, clears on write 1.
// - First-lock enable bit passes or blocks its latched bit as a request.
// - First lock indicator is shown live, 1 meaning locked.
// - Input valid latched bit sets on each change, clears while its inClkValidClear bit is 1.
module ists_top #(
    parameter PA_W = 1,
    parameter MAB_W = 1,
    parameter OC_W = 8,
    parameter DPLL_W = 16
) (
    input wire ref_clk,
    input wire rst_b,
    input wire [7:0] regAddr,
    input wire regWrEn,
    input wire [7:0] regWrData,
    input wire regRdEn,
    output reg [7:0] regRdData,
    output reg regRdValid,
    input wire gpPin0Level,
    input wire gpPinFollowIrq,
    output reg gpPinIrqOut,
    output reg irqSummary,
    input wire bootCtrlDone,
    input wire [PA_W-1:0] phaseAdjLatched,
    input wire [PA_W-1:0] phaseAdjIrqEn,
    input wire [MAB_W-1:0] abMeasureLatched,
    input wire [MAB_W-1:0] abMeasureIrqEn,
    input wire [2:0] inClkValid,
    input wire [2:0] inClkValidIrqEn,
    input wire [2:0] inClkValidClear,
    output reg [2:0] inClkValidLatched,
    input wire [3*OC_W-1:0] outClkLatched,
    input wire [3*OC_W-1:0] outClkIrqEn,
    input wire [DPLL_W-1:0] digPllLatched,
    input wire [DPLL_W-1:0] digPllIrqEn,
    input wire lockIndFirst,
    input wire lockIndSecond,
    input wire digPllLocked
);

    // Hardware set wins over a clear in the same cycle
    function latchNext;
        input cur;
        input setEv;
        input clrEv;
        begin
            latchNext = setEv | (cur & ~clrEv);
        end
    endfunction

    function isWrite;
        input [7:0] addr;
        input [7:0] off;
        input wrEn;
        begin
            isWrite = wrEn & (addr == off);
        end
    endfunction

    reg [7:0] topSummary_reg;
    reg [7:0] topSummary_next;
    reg [7:0] globalFunc_reg;
    reg [7:0] globalFunc_next;
    reg [7:0] inClkStat_reg;
    reg [7:0] inClkStat_next;
    reg [7:0] outClkStat_reg;
    reg [7:0] outClkStat_next;
    reg [7:0] apllStat_reg;
    reg [7:0] apllStat_next;
    reg [7:0] dpllStat_reg;
    reg [7:0] dpllStat_next;
    reg [7:0] apllLock_reg;
    reg [7:0] apllLock_next;
    reg bootDone_reg;
    reg primed_reg;
    reg lockFirstPrev_reg;
    reg lockSecondPrev_reg;
    reg [2:0] inValidPrev_reg;
    wire [2:0] inValidLat_next;
    wire [2:0] outClkFlag;
    reg [7:0] rdMux;
    wire wrTop;
    wire wrLock;
    wire firstChange;
    wire secondChange;

    assign wrTop = isWrite(regAddr, `ISTS_OFF_TOP_SUMMARY, regWrEn);
    assign wrLock = isWrite(regAddr, `ISTS_OFF_APLL_LOCK, regWrEn);
    // Change detection held off for the first cycle after reset so a locked
    // PLL at release does not raise a spurious event.
    assign firstChange = primed_reg & (lockIndFirst != lockFirstPrev_reg);
    assign secondChange = primed_reg & (lockIndSecond != lockSecondPrev_reg);

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1)
        begin : gChan
            assign outClkFlag[gi] = |(outClkLatched[gi*OC_W +: OC_W] & outClkIrqEn[gi*OC_W +: OC_W]);
            assign inValidLat_next[gi] = latchNext(inClkValidLatched[gi],
                primed_reg & (inClkValid[gi] != inValidPrev_reg[gi]), inClkValidClear[gi]);
        end
    endgenerate

    // Analog PLL lock register: live bits, W1C latched bits, enables
    // Live bits are registered, so they lag their inputs by one cycle
    always @*
    begin
        apllLock_next = apllLock_reg;
        apllLock_next[7] = 1'b0;
        apllLock_next[`ISTS_LK_FIRST_BIT] = lockIndFirst;
        apllLock_next[`ISTS_LK_SECOND_BIT] = lockIndSecond;
        apllLock_next[`ISTS_LK_BOTH_BIT] = lockIndFirst & lockIndSecond & digPllLocked;
        apllLock_next[`ISTS_LK_FIRST_LAT_BIT] = latchNext(apllLock_reg[`ISTS_LK_FIRST_LAT_BIT], firstChange,
            wrLock & regWrData[`ISTS_LK_FIRST_LAT_BIT]);
        apllLock_next[`ISTS_LK_SECOND_LAT_BIT] = latchNext(apllLock_reg[`ISTS_LK_SECOND_LAT_BIT], secondChange,
            wrLock & regWrData[`ISTS_LK_SECOND_LAT_BIT]);
        if (wrLock)
        begin
            apllLock_next[`ISTS_LK_FIRST_EN_BIT] = regWrData[`ISTS_LK_FIRST_EN_BIT];
            apllLock_next[`ISTS_LK_SECOND_EN_BIT] = regWrData[`ISTS_LK_SECOND_EN_BIT];
        end
    end

    // Group registers, rebuilt every cycle from current sources
    always @*
    begin
        globalFunc_next = `ISTS_REG_RESET;
        globalFunc_next[`ISTS_MISC_GROUP_FLAG_BOOT_BIT] = bootDone_reg | bootCtrlDone;
        globalFunc_next[`ISTS_MISC_GROUP_FLAG_PA_BIT] = |(phaseAdjLatched & phaseAdjIrqEn);
        globalFunc_next[`ISTS_MISC_GROUP_FLAG_MAB_BIT] = |(abMeasureLatched & abMeasureIrqEn);
        inClkStat_next = {5'h00, inClkValidLatched & inClkValidIrqEn};
        outClkStat_next = {5'h00, outClkFlag};
        apllStat_next = `ISTS_REG_RESET;
        apllStat_next[0] = (apllLock_reg[`ISTS_LK_FIRST_LAT_BIT] & apllLock_reg[`ISTS_LK_FIRST_EN_BIT]) |
            (apllLock_reg[`ISTS_LK_SECOND_LAT_BIT] & apllLock_reg[`ISTS_LK_SECOND_EN_BIT]);
        dpllStat_next = `ISTS_REG_RESET;
        dpllStat_next[0] = |(digPllLatched & digPllIrqEn);
    end

    // Top summary; only the global enable is writable
    // Boot-done counts as a misc source, so after boot the summary stays set while enabled
    always @*
    begin
        topSummary_next = `ISTS_REG_RESET;
        topSummary_next[`ISTS_TOP_MISC_BIT] = |globalFunc_next;
        topSummary_next[`ISTS_TOP_OUTCLK_BIT] = |outClkStat_next;
        topSummary_next[`ISTS_TOP_INCLK_BIT] = |inClkStat_next;
        topSummary_next[`ISTS_TOP_DPLL_BIT] = |dpllStat_next;
        topSummary_next[`ISTS_TOP_APLL_BIT] = |apllStat_next;
        topSummary_next[`ISTS_TOP_GEN_BIT] = wrTop ? regWrData[`ISTS_TOP_GEN_BIT] :
            topSummary_reg[`ISTS_TOP_GEN_BIT];
        topSummary_next[`ISTS_TOP_INT_BIT] = topSummary_next[`ISTS_TOP_GEN_BIT] &
            (|topSummary_next[`ISTS_TOP_MISC_BIT:`ISTS_TOP_APLL_BIT]);
    end

    // Read side has no side effects on any latched bit
    always @*
    begin
        case (regAddr)
            `ISTS_OFF_GP_PIN_STATUS: rdMux = {7'h00, gpPin0Level};
            `ISTS_OFF_TOP_SUMMARY: rdMux = topSummary_reg;
            `ISTS_OFF_GLOBAL_FUNC: rdMux = globalFunc_reg;
            `ISTS_OFF_INPUT_CLK: rdMux = inClkStat_reg;
            `ISTS_OFF_OUTPUT_CLK: rdMux = outClkStat_reg;
            `ISTS_OFF_ANALOG_PLL: rdMux = apllStat_reg;
            `ISTS_OFF_DIGITAL_PLL: rdMux = dpllStat_reg;
            `ISTS_OFF_APLL_LOCK: rdMux = apllLock_reg;
            default: rdMux = 8'h00;
        endcase
    end

    // Group registers and the summary flags are rebuilt from live sources each cycle; the global enable bit holds until written
    always @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            topSummary_reg <= `ISTS_REG_RESET;
        end
        else
        begin
            topSummary_reg <= topSummary_next;
        end
    end

    always @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            globalFunc_reg <= `ISTS_REG_RESET;
            bootDone_reg <= 1'b0;
        end
        else
        begin
            globalFunc_reg <= globalFunc_next;
            bootDone_reg <= bootDone_reg | bootCtrlDone;
        end
    end

    always @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            inClkStat_reg <= `ISTS_REG_RESET;
            outClkStat_reg <= `ISTS_REG_RESET;
        end
        else
        begin
            inClkStat_reg <= inClkStat_next;
            outClkStat_reg <= outClkStat_next;
        end
    end

    always @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            apllStat_reg <= `ISTS_REG_RESET;
            dpllStat_reg <= `ISTS_REG_RESET;
        end
        else
        begin
            apllStat_reg <= apllStat_next;
            dpllStat_reg <= dpllStat_next;
        end
    end

    always @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            apllLock_reg <= `ISTS_REG_RESET;
        end
        else
        begin
            apllLock_reg <= apllLock_next;
        end
    end

    // Lock history; the first cycle after reset only loads it
    always @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            primed_reg <= 1'b0;
            lockFirstPrev_reg <= 1'b0;
            lockSecondPrev_reg <= 1'b0;
        end
        else
        begin
            primed_reg <= 1'b1;
            lockFirstPrev_reg <= lockIndFirst;
            lockSecondPrev_reg <= lockIndSecond;
        end
    end

    always @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            inValidPrev_reg <= 3'h0;
            inClkValidLatched <= 3'h0;
        end
        else
        begin
            inValidPrev_reg <= inClkValid;
            inClkValidLatched <= inValidLat_next;
        end
    end

    // Read data holds between reads so a slow host can pick it up later
    always @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            regRdData <= 8'h00;
        end
        else
        begin
            regRdData <= regRdEn ? rdMux : regRdData;
        end
    end

    always @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            regRdValid <= 1'b0;
        end
        else
        begin
            regRdValid <= regRdEn;
        end
    end

    always @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            gpPinIrqOut <= 1'b0;
        end
        else
        begin
            gpPinIrqOut <= gpPinFollowIrq & topSummary_next[`ISTS_TOP_INT_BIT];
        end
    end

    always @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            irqSummary <= 1'b0;
        end
        else
        begin
            irqSummary <= topSummary_next[`ISTS_TOP_INT_BIT];
        end
    end

endmodule // ists_top
`default_nettype wire

// ===== verif/ists_checker_properties.sv
// Checker for the status tree top module ports.
// Assumes single clock domain and synchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none
module ists_checker (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [7:0] regAddr,
    input wire logic regWrEn,
    input wire logic [7:0] regWrData,
    input wire logic regRdEn,
    input wire logic [7:0] regRdData,
    input wire logic gpPin0Level,
    input wire logic gpPinFollowIrq,
    input wire logic gpPinIrqOut,
    input wire logic irqSummary,
    input wire logic [2:0] inClkValid,
    input wire logic [2:0] inClkValidLatched,
    input wire logic lockIndFirst,
    input wire logic lockIndSecond,
    input wire logic digPllLocked
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    logic en42;
    logic enFirst;
    logic enSecond;
    // Shadows of the writable enables
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            en42 <= 1'b0;
            enFirst <= 1'b0;
            enSecond <= 1'b0;
        end
        else if (regWrEn && regAddr == 8'h42)
            en42 <= regWrData[1];
        else if (regWrEn && regAddr == 8'h48)
        begin
            enFirst <= regWrData[2];
            enSecond <= regWrData[6];
        end
    end
    sequence s_irq_soon;
        ##[1:3] irqSummary;
    endsequence
    sequence s_first_chg;
        rst_b && $past(rst_b) && $changed(lockIndFirst) && enFirst && en42;
    endsequence
    sequence s_second_chg;
        rst_b && $past(rst_b) && $changed(lockIndSecond) && enSecond && en42;
    endsequence
    property p_gen_block;
        !en42 |-> !irqSummary;
    endproperty
    property p_sum_read;
        regRdEn && regAddr == 8'h42 |=> regRdData[1:0] == {$past(en42), $past(irqSummary)} && !regRdData[7];
    endproperty
    property p_pin_level;
        regRdEn && regAddr == 8'h41 |=> regRdData == {7'h00, $past(gpPin0Level)};
    endproperty
    property p_pin_follow;
        $past(gpPinFollowIrq) == $past(gpPinFollowIrq, 2) && $stable(irqSummary)
            |-> gpPinIrqOut == ($past(gpPinFollowIrq) & irqSummary);
    endproperty
    property p_valid_latch;
        rst_b && $past(rst_b) |=> (inClkValidLatched & ($past(inClkValid) ^ $past(inClkValid, 2)))
            == ($past(inClkValid) ^ $past(inClkValid, 2));
    endproperty
    property p_lock_first;
        s_first_chg |-> s_irq_soon;
    endproperty
    property p_lock_second;
        s_second_chg |-> s_irq_soon;
    endproperty
    property p_lock_read;
        regRdEn && regAddr == 8'h48 && $stable(lockIndFirst) && $stable(lockIndSecond) && $stable(digPllLocked)
            |=> regRdData[0] == $past(lockIndFirst) && regRdData[4] == $past(lockIndSecond)
            && regRdData[3] == ($past(lockIndFirst) & $past(lockIndSecond) & $past(digPllLocked));
    endproperty
    a_gen_block: assert property (p_gen_block) else $error("summary set while disabled");
    a_sum_read: assert property (p_sum_read) else $error("top summary read wrong");
    a_pin_level: assert property (p_pin_level) else $error("pin level read wrong");
    a_pin_follow: assert property (p_pin_follow) else $error("pin does not follow summary");
    a_valid_latch: assert property (p_valid_latch) else $error("valid change not latched");
    a_lock_first: assert property (p_lock_first) else $error("first lock change no request");
    a_lock_second: assert property (p_lock_second) else $error("second lock change no request");
    a_lock_read: assert property (p_lock_read) else $error("lock status read wrong");
endmodule // ists_checker
bind ists_top ists_checker u_chk (.ref_clk(ref_clk), .rst_b(rst_b), .regAddr(regAddr), .regWrEn(regWrEn),
    .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData), .gpPin0Level(gpPin0Level),
    .gpPinFollowIrq(gpPinFollowIrq), .gpPinIrqOut(gpPinIrqOut), .irqSummary(irqSummary),
    .inClkValid(inClkValid), .inClkValidLatched(inClkValidLatched), .lockIndFirst(lockIndFirst),
    .lockIndSecond(lockIndSecond), .digPllLocked(digPllLocked));
`default_nettype wire

// ===== verif/ists_host_model.sv
// Host model: reads and writes the status registers.
// Assumes the bench drives on the falling edge of ref_clk.
`timescale 1ns/10ps
`default_nettype none
module ists_host (
    input wire logic ref_clk,
    input wire logic [7:0] regRdData,
    input wire logic regRdValid,
    output logic [7:0] regAddr,
    output logic regWrEn,
    output logic [7:0] regWrData,
    output logic regRdEn
);
    initial
    begin
        regAddr = 8'h00;
        regWrEn = 1'b0;
        regWrData = 8'h00;
        regRdEn = 1'b0;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        regAddr = a;
        regWrData = d;
        regWrEn = 1'b1;
        @(negedge ref_clk);
        regWrEn = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        int n;
        @(negedge ref_clk);
        regAddr = a;
        regRdEn = 1'b1;
        @(negedge ref_clk);
        regRdEn = 1'b0;
        n = 0;
        while (regRdValid !== 1'b1 && n < 3)
        begin
            @(negedge ref_clk);
            n++;
        end
        // A missing answer returns unknowns so the caller's compare counts it
        d = (regRdValid === 1'b1) ? regRdData : 8'hxx;
    endtask
    // Both lock indicators needed
    function automatic logic pll_locked(input logic [7:0] v);
        return v[0] & v[4];
    endfunction
endmodule // ists_host
`default_nettype wire

// ===== verif/tb_interrupt_status_tree.sv
// Self-checking bench for the status tree.
// Assumes the host model and bound checker compiled first.
`timescale 1ns/10ps
`default_nettype none
module tb_interrupt_status_tree;
    logic ref_clk, rst_b, regWrEn, regRdEn, regRdValid, gpPin0Level, gpPinFollowIrq, gpPinIrqOut, irqSummary;
    logic bootCtrlDone, phaseAdjLatched, phaseAdjIrqEn, abMeasureLatched, abMeasureIrqEn;
    logic lockIndFirst, lockIndSecond, digPllLocked;
    logic [7:0] regAddr, regWrData, regRdData;
    logic [2:0] inClkValid, inClkValidIrqEn, inClkValidClear, inClkValidLatched;
    logic [23:0] outClkLatched, outClkIrqEn;
    logic [15:0] digPllLatched, digPllIrqEn;
    int fails, num_checks;
    ists_top u_dut (.ref_clk(ref_clk), .rst_b(rst_b), .regAddr(regAddr), .regWrEn(regWrEn),
        .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData), .regRdValid(regRdValid),
        .gpPin0Level(gpPin0Level), .gpPinFollowIrq(gpPinFollowIrq), .gpPinIrqOut(gpPinIrqOut),
        .irqSummary(irqSummary), .bootCtrlDone(bootCtrlDone), .phaseAdjLatched(phaseAdjLatched),
        .phaseAdjIrqEn(phaseAdjIrqEn), .abMeasureLatched(abMeasureLatched), .abMeasureIrqEn(abMeasureIrqEn),
        .inClkValid(inClkValid), .inClkValidIrqEn(inClkValidIrqEn), .inClkValidClear(inClkValidClear),
        .inClkValidLatched(inClkValidLatched), .outClkLatched(outClkLatched), .outClkIrqEn(outClkIrqEn),
        .digPllLatched(digPllLatched), .digPllIrqEn(digPllIrqEn), .lockIndFirst(lockIndFirst),
        .lockIndSecond(lockIndSecond), .digPllLocked(digPllLocked));
    ists_host u_host (.ref_clk(ref_clk), .regRdData(regRdData), .regRdValid(regRdValid), .regAddr(regAddr),
        .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn));
    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e)
        begin
            fails++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        u_host.rd(a, d);
        chk($sformatf("reg %h", a), e, d);
    endtask
    task automatic t_reset_map();
        u_host.wr(8'h42, 8'hfd);
        u_host.wr(8'h43, 8'hff);
        for (int a = 'h41; a <= 'h49; a++)
            rchk(a[7:0], 8'h00);
    endtask
    task automatic t_groups();
        logic [7:0] ga [6] = '{8'h43, 8'h43, 8'h45, 8'h47, 8'h44, 8'h46};
        logic [7:0] gv [6] = '{8'h02, 8'h03, 8'h02, 8'h01, 8'h04, 8'h01};
        logic [7:0] tv [6] = '{8'h43, 8'h43, 8'h63, 8'h6b, 8'h7b, 8'h7f};
        u_host.wr(8'h42, 8'h02);
        u_host.wr(8'h48, 8'h04);
        for (int i = 0; i < 6; i++)
        begin
            case (i)
                0: phaseAdjLatched = 1'b1;
                1: abMeasureLatched = 1'b1;
                2: outClkLatched[11] = 1'b1;
                3: digPllLatched[12] = 1'b1;
                4: inClkValid[2] = 1'b1;
                default: lockIndFirst = 1'b1;
            endcase
            repeat (3) @(negedge ref_clk);
            rchk(ga[i], gv[i]);
            rchk(8'h42, tv[i]);
            chk("irq", 8'h01, {7'h00, irqSummary});
            chk("pin", 8'h01, {7'h00, gpPinIrqOut});
        end
        u_host.wr(8'h42, 8'h00);
        rchk(8'h42, 8'h7c);
        {phaseAdjIrqEn, abMeasureIrqEn, inClkValidIrqEn} = 5'h00;
        outClkIrqEn = 24'h000000;
        digPllIrqEn = 16'h0000;
        repeat (2) @(negedge ref_clk);
        rchk(8'h43, 8'h00);
        rchk(8'h44, 8'h00);
        rchk(8'h45, 8'h00);
        rchk(8'h47, 8'h00);
        {phaseAdjIrqEn, abMeasureIrqEn, inClkValidIrqEn} = 5'h1f;
        outClkIrqEn = 24'hffffff;
        digPllIrqEn = 16'hffff;
        phaseAdjLatched = 1'b0;
        abMeasureLatched = 1'b0;
        outClkLatched = 24'h000000;
        digPllLatched = 16'h0000;
        @(negedge ref_clk);
        chk("vlat set", 8'h04, {5'h00, inClkValidLatched});
        inClkValidClear = 3'h7;
        @(negedge ref_clk);
        inClkValidClear = 3'h0;
        chk("vlat clr", 8'h00, {5'h00, inClkValidLatched});
        u_host.wr(8'h48, 8'h22);
        u_host.wr(8'h42, 8'h02);
        rchk(8'h44, 8'h00);
        rchk(8'h42, 8'h02);
    endtask
    task automatic t_lock();
        logic [7:0] d;
        lockIndSecond = 1'b1;
        digPllLocked = 1'b1;
        repeat (3) @(negedge ref_clk);
        rchk(8'h48, 8'h39);
        u_host.rd(8'h48, d);
        chk("locked", 8'h01, {7'h00, u_host.pll_locked(d)});
        rchk(8'h46, 8'h00);
        u_host.wr(8'h48, 8'h40);
        rchk(8'h46, 8'h01);
        u_host.wr(8'h48, 8'h60);
        rchk(8'h48, 8'h59);
        digPllLocked = 1'b0;
        repeat (2) @(negedge ref_clk);
        rchk(8'h48, 8'h51);
        lockIndSecond = 1'b0;
        repeat (3) @(negedge ref_clk);
        rchk(8'h48, 8'h61);
        rchk(8'h48, 8'h61);
    endtask
    task automatic t_pin_boot();
        gpPin0Level = 1'b1;
        rchk(8'h41, 8'h01);
        gpPin0Level = 1'b0;
        rchk(8'h41, 8'h00);
        u_host.wr(8'h48, 8'h20);
        @(negedge ref_clk);
        bootCtrlDone = 1'b1;
        @(negedge ref_clk);
        bootCtrlDone = 1'b0;
        repeat (3) @(negedge ref_clk);
        rchk(8'h43, 8'h80);
        rchk(8'h42, 8'h43);
        gpPinFollowIrq = 1'b0;
        repeat (2) @(negedge ref_clk);
        chk("pin off", 8'h00, {7'h00, gpPinIrqOut});
        chk("irq on", 8'h01, {7'h00, irqSummary});
        rst_b = 1'b0;
        repeat (2) @(negedge ref_clk);
        rst_b = 1'b1;
        rchk(8'h43, 8'h00);
        rchk(8'h48, 8'h01);
        chk("irq rst", 8'h00, {7'h00, irqSummary});
    endtask
    task automatic summarize();
        if (fails == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial
    begin
        {rst_b, bootCtrlDone, phaseAdjLatched, abMeasureLatched, gpPin0Level} = 5'h00;
        {lockIndFirst, lockIndSecond, digPllLocked, inClkValid, inClkValidClear} = 9'h000;
        {phaseAdjIrqEn, abMeasureIrqEn, gpPinFollowIrq, inClkValidIrqEn} = 6'h3f;
        outClkLatched = 24'h000000;
        outClkIrqEn = 24'hffffff;
        digPllLatched = 16'h0000;
        digPllIrqEn = 16'hffff;
        repeat (20) @(negedge ref_clk);
        rst_b = 1'b1;
        t_reset_map();
        t_groups();
        t_lock();
        t_pin_boot();
        summarize();
    end
    // Whole run needs well under 2000 cycles
    initial
    begin
        #50000;
        fails++;
        summarize();
    end
endmodule // tb_interrupt_status_tree
`default_nettype wire
